//--- rtl/mtr_consts.svh
`ifndef MTR_CONSTS_SVH
`define MTR_CONSTS_SVH

// bus widths
`define MTR_ADDR_W 8
`define MTR_DATA_W 32

// register byte addresses
`define MTR_OFF_CTRL 8'h80
`define MTR_OFF_SEL 8'h84
`define MTR_OFF_CNT_LO 8'h88
`define MTR_OFF_CNT_HI 8'h8C
`define MTR_OFF_WRAP0 8'h90
`define MTR_OFF_WRAP1 8'h94
`define MTR_OFF_WRAP2 8'h98
`define MTR_OFF_ROUTE 8'h9C
`define MTR_OFF_ROUTE_EXT 8'hA0
`define MTR_OFF_IRQ_STAT 8'hA4
`define MTR_OFF_IRQ_MASK 8'hA8

// timer_control fields
`define MTR_CTRL_RUN 0
`define MTR_CTRL_SYNC 1
`define MTR_CTRL_STATE 2
`define MTR_CTRL_LATCH 3
`define MTR_CTRL_SYNC_RST 1'h1

// selector register fields
`define MTR_SEL_CNT_LSB 0
`define MTR_SEL_WRAP_LSB 4
`define MTR_SEL_EXT 8
`define MTR_SEL_LATCH_CODE 3'h0

// event codes and event vector
`define MTR_NUM_EVT 8
`define MTR_CODE_FIRST_RSV 4'h6
`define MTR_CODE_LAST_EVT 4'h9
`define MTR_CODE_BASIC_NONE 3'h7
`define MTR_CODE_LONG_ONE 4'h8

`endif

//--- rtl/mtr_pkg.sv
package mtr_pkg;
    typedef logic [7:0] mtr_byte_type;
    typedef logic [3:0] mtr_code_type;
    typedef enum logic {MTR_IDLE, MTR_RUNNING} mtr_run_state_type;
endpackage

//--- rtl/mtr_event_router.sv
`timescale 1ns/1ps
`default_nettype none
`include "mtr_consts.svh"

module mtr_event_router
    import mtr_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // source selection
    input wire logic [3:0] i_code,
    input wire logic [`MTR_NUM_EVT-1:0] i_events,
    // routed pulse
    output logic o_pulse
);
    logic pulse_ff;
    logic nxt_pulse;

    // codes 6, 7 and 10..15 route nothing
    function automatic logic pick(input mtr_code_type code,
                                  input logic [`MTR_NUM_EVT-1:0] ev);
        logic hit;
        hit = 1'b0;
        if (code < `MTR_CODE_FIRST_RSV) begin
            hit = ev[code[2:0]];
        end else if (code >= `MTR_CODE_LONG_ONE &&
                     code <= `MTR_CODE_LAST_EVT) begin
            hit = ev[{2'h3, code[0]}];
        end
        return hit;
    endfunction

    // selected source
    assign nxt_pulse = pick(i_code, i_events); // see R6 see R8

    // registered pulse output
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= nxt_pulse;
        end
    end

    assign o_pulse = pulse_ff;
endmodule
`default_nettype wire

//--- rtl/mtr_sticky_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "mtr_consts.svh"

module mtr_sticky_irq
    import mtr_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // event sources
    input wire logic [`MTR_NUM_EVT-1:0] i_events,
    // software access
    input wire logic i_stat_clr,
    input wire logic i_mask_wr,
    input wire logic [`MTR_NUM_EVT-1:0] i_wdata,
    // state and interrupt
    output logic [`MTR_NUM_EVT-1:0] o_status,
    output logic [`MTR_NUM_EVT-1:0] o_mask,
    output logic o_irq
);
    logic [`MTR_NUM_EVT-1:0] stat_ff;
    logic [`MTR_NUM_EVT-1:0] mask_ff;
    logic irq_ff;
    logic [`MTR_NUM_EVT-1:0] nxt_stat;
    logic [`MTR_NUM_EVT-1:0] clr_bits;

    // write one clears, a new event wins over the clear
    assign clr_bits = i_stat_clr ? i_wdata : '0;
    assign nxt_stat = (stat_ff & ~clr_bits) | i_events;

    // status, mask and level interrupt
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            stat_ff <= '0;
            mask_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            if (i_mask_wr) begin
                mask_ff <= i_wdata;
            end
            irq_ff <= |(nxt_stat & (i_mask_wr ? i_wdata : mask_ff));
        end
    end

    assign o_status = stat_ff;
    assign o_mask = mask_ff;
    assign o_irq = irq_ff;
endmodule
`default_nettype wire

//--- rtl/mtr_timer_ctrl.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mtr_consts.svh"

// Contract
// R1 - With latch mode 0 and selector 000, a low-byte read latches the high byte, and a wrap byte 0 read latches the upper two wrap bytes.
// R2 - With latch mode 1 and selector 000, a low-byte read latches the high byte and all three wrap bytes together.
// R3 - With the sync bit 0 the timer starts or stops on the next fast clock after the run bit changes.
// R4 - With the sync bit 1, its reset value, start or stop waits for the first rising edge of the slow clock.
// R5 - Software writes 1 to run and 0 to stop, and reading the run bit gives back the last written value.
// R6 - The basic layout routes event output two from bits 6:4 with codes 0..5 as sources, 110 reserved and 111 none.
// R7 - The basic layout routes event output one from bits 2:0 with the same codes, bits 7 and 3 reading zero.
// R8 - The extended layout routes event output two from bits 7:4, adding 1000 and 1001 for the combined matches, 1010..1110 reserved, 1111 none.
// R9 - The extended layout routes event output one from bits 3:0 with the same extended codes.
// R10 - Bit 2 of the control register reads 0 while idle and 1 while running, following any deferred start or stop.
// R11 - A period event fires when a counter wraps to zero instead of reaching its period, for the count and the wrap counter.
// R12 - A combined match fires when the wrap counter equals its compare and the count reaches its matching compare at once.
module mtr_timer_ctrl
    import mtr_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`MTR_ADDR_W-1:0] i_paddr,
    input wire logic [`MTR_DATA_W-1:0] i_pwdata,
    output logic [`MTR_DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // timer core status
    input wire logic i_slow_clock,
    input wire logic [15:0] i_count_value,
    input wire logic [23:0] i_wrap_value,
    input wire logic i_count_match_one,
    input wire logic i_count_match_two,
    input wire logic i_wrap_match_one,
    input wire logic i_wrap_match_two,
    input wire logic i_wrap_equals_one,
    input wire logic i_wrap_equals_two,
    // timer core control and events
    output logic o_timer_running,
    output logic o_event_out_one,
    output logic o_event_out_two,
    output logic o_irq
);
    // software registers
    logic run_ff;
    logic sync_ff;
    logic latch_mode_ff;
    logic [2:0] count_byte_selector_ff;
    logic [2:0] wrap_byte_selector_ff;
    logic ext_layout_ff;
    mtr_byte_type route_basic_ff;
    mtr_byte_type route_ext_ff;
    // snapshot registers
    mtr_byte_type count_hi_ff;
    logic [23:0] wrap_snap_ff;
    // timer state and event history
    mtr_run_state_type state_ff;
    mtr_run_state_type nxt_state;
    logic slow_prev_ff;
    logic [15:0] count_prev_ff;
    logic [23:0] wrap_prev_ff;
    // bus answer
    logic pready_ff;
    logic pslverr_ff;
    logic [`MTR_DATA_W-1:0] prdata_ff;

    // bus phases: reads take effect at setup, writes at completion
    logic setup_rd;
    logic wr_done;
    logic addr_hit;
    logic [`MTR_DATA_W-1:0] rd_word;
    assign setup_rd = i_psel && !i_penable && !i_pwrite;
    assign wr_done = i_psel && i_penable && pready_ff && i_pwrite;

    // register decode
    logic sel_ctrl, sel_sel, sel_cnt_lo, sel_cnt_hi;
    logic sel_w0, sel_w1, sel_w2, sel_route, sel_ext, sel_stat, sel_mask;
    assign sel_ctrl = i_paddr == `MTR_OFF_CTRL;
    assign sel_sel = i_paddr == `MTR_OFF_SEL;
    assign sel_cnt_lo = i_paddr == `MTR_OFF_CNT_LO;
    assign sel_cnt_hi = i_paddr == `MTR_OFF_CNT_HI;
    assign sel_w0 = i_paddr == `MTR_OFF_WRAP0;
    assign sel_w1 = i_paddr == `MTR_OFF_WRAP1;
    assign sel_w2 = i_paddr == `MTR_OFF_WRAP2;
    assign sel_route = i_paddr == `MTR_OFF_ROUTE;
    assign sel_ext = i_paddr == `MTR_OFF_ROUTE_EXT;
    assign sel_stat = i_paddr == `MTR_OFF_IRQ_STAT;
    assign sel_mask = i_paddr == `MTR_OFF_IRQ_MASK;
    assign addr_hit = sel_ctrl | sel_sel | sel_cnt_lo | sel_cnt_hi | sel_w0
        | sel_w1 | sel_w2 | sel_route | sel_ext | sel_stat | sel_mask;

    // snapshot triggers
    logic cnt_sel0, wrap_sel0, lo_read, w0_read;
    assign cnt_sel0 = count_byte_selector_ff == `MTR_SEL_LATCH_CODE;
    assign wrap_sel0 = wrap_byte_selector_ff == `MTR_SEL_LATCH_CODE;
    assign lo_read = setup_rd && sel_cnt_lo && cnt_sel0;
    assign w0_read = setup_rd && sel_w0 && wrap_sel0 && !latch_mode_ff;

    // snapshot capture
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            count_hi_ff <= 8'h00;
            wrap_snap_ff <= 24'h000000;
        end else begin
            if (lo_read) begin
                count_hi_ff <= i_count_value[15:8]; // see R1 see R2
            end
            if (lo_read && latch_mode_ff) begin
                wrap_snap_ff <= i_wrap_value; // see R2
            end else if (w0_read) begin
                wrap_snap_ff[23:8] <= i_wrap_value[23:8]; // see R1
            end
        end
    end

    // window read values, wrap byte 0 is live unless snapshot mode
    mtr_byte_type lo_rd, hi_rd, w0_rd, w1_rd, w2_rd;
    assign lo_rd = cnt_sel0 ? i_count_value[7:0] : 8'h00;
    assign hi_rd = cnt_sel0 ? count_hi_ff : 8'h00;
    assign w0_rd = !wrap_sel0 ? 8'h00 :
        (latch_mode_ff ? wrap_snap_ff[7:0] : i_wrap_value[7:0]);
    assign w1_rd = wrap_sel0 ? wrap_snap_ff[15:8] : 8'h00;
    assign w2_rd = wrap_sel0 ? wrap_snap_ff[23:16] : 8'h00;

    // control word: run reads back as written, state shows the timer
    mtr_byte_type ctrl_rd, route_rd;
    assign ctrl_rd = {4'h0, latch_mode_ff, state_ff == MTR_RUNNING,
                      sync_ff, run_ff}; // see R5 see R10
    assign route_rd = {1'b0, route_basic_ff[6:4], 1'b0,
                       route_basic_ff[2:0]}; // see R7

    // events and interrupt state
    logic [`MTR_NUM_EVT-1:0] events;
    logic [`MTR_NUM_EVT-1:0] irq_stat;
    logic [`MTR_NUM_EVT-1:0] irq_mask;

    // read data selection
    assign rd_word =
        sel_ctrl ? {24'h000000, ctrl_rd} :
        sel_sel ? {23'h000000, ext_layout_ff, 1'b0, wrap_byte_selector_ff,
                   1'b0, count_byte_selector_ff} :
        sel_cnt_lo ? {24'h000000, lo_rd} :
        sel_cnt_hi ? {24'h000000, hi_rd} :
        sel_w0 ? {24'h000000, w0_rd} :
        sel_w1 ? {24'h000000, w1_rd} :
        sel_w2 ? {24'h000000, w2_rd} :
        sel_route ? {24'h000000, route_rd} :
        sel_ext ? {24'h000000, route_ext_ff} :
        sel_stat ? {24'h000000, irq_stat} :
        sel_mask ? {24'h000000, irq_mask} : 32'h00000000;

    // apb answer: one wait-free access phase, error on unmapped address
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= i_psel && !i_penable;
            if (i_psel && !i_penable) begin
                pslverr_ff <= !addr_hit;
                prdata_ff <= i_pwrite ? 32'h00000000 : rd_word;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // software register writes
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            run_ff <= 1'b0;
            sync_ff <= `MTR_CTRL_SYNC_RST;
            latch_mode_ff <= 1'b0;
            count_byte_selector_ff <= 3'h0;
            wrap_byte_selector_ff <= 3'h0;
            ext_layout_ff <= 1'b0;
            route_basic_ff <= 8'h00;
            route_ext_ff <= 8'h00;
        end else if (wr_done) begin
            if (sel_ctrl) begin
                run_ff <= i_pwdata[`MTR_CTRL_RUN]; // see R5
                sync_ff <= i_pwdata[`MTR_CTRL_SYNC];
                latch_mode_ff <= i_pwdata[`MTR_CTRL_LATCH];
            end
            if (sel_sel) begin
                count_byte_selector_ff <= i_pwdata[`MTR_SEL_CNT_LSB+:3];
                wrap_byte_selector_ff <= i_pwdata[`MTR_SEL_WRAP_LSB+:3];
                ext_layout_ff <= i_pwdata[`MTR_SEL_EXT];
            end
            if (sel_route) begin
                route_basic_ff <= i_pwdata[7:0] & 8'h77; // see R7
            end
            if (sel_ext) begin
                route_ext_ff <= i_pwdata[7:0];
            end
        end
    end

    // start and stop, immediate or on the slow clock rising edge
    logic slow_rise;
    assign slow_rise = i_slow_clock && !slow_prev_ff;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MTR_IDLE: begin
                if (run_ff && (!sync_ff || slow_rise)) begin // see R3 see R4
                    nxt_state = MTR_RUNNING;
                end
            end
            MTR_RUNNING: begin
                if (!run_ff && (!sync_ff || slow_rise)) begin // see R3 see R4
                    nxt_state = MTR_IDLE;
                end
            end
            default: begin
                nxt_state = MTR_IDLE;
            end
        endcase
    end

    // timer state and counter history
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_ff <= MTR_IDLE;
            slow_prev_ff <= 1'b0;
            count_prev_ff <= 16'h0000;
            wrap_prev_ff <= 24'h000000;
        end else begin
            state_ff <= nxt_state;
            slow_prev_ff <= i_slow_clock;
            count_prev_ff <= i_count_value;
            wrap_prev_ff <= i_wrap_value;
        end
    end
    assign o_timer_running = state_ff == MTR_RUNNING;

    // event sources: wraps to zero, direct matches and combined matches
    logic running;
    assign running = state_ff == MTR_RUNNING;
    assign events[0] = running && count_prev_ff != 16'h0000 &&
        i_count_value == 16'h0000; // see R11
    assign events[1] = i_count_match_one;
    assign events[2] = i_count_match_two;
    assign events[3] = running && wrap_prev_ff != 24'h000000 &&
        i_wrap_value == 24'h000000; // see R11
    assign events[4] = i_wrap_match_one;
    assign events[5] = i_wrap_match_two;
    assign events[6] = i_wrap_equals_one && i_count_match_one; // see R12
    assign events[7] = i_wrap_equals_two && i_count_match_two; // see R12

    // route codes per output, basic codes padded to four bits
    logic [3:0] code_one, code_two;
    assign code_one = ext_layout_ff ? route_ext_ff[3:0] :
        {1'b0, route_basic_ff[2:0]}; // see R7 see R9
    assign code_two = ext_layout_ff ? route_ext_ff[7:4] :
        {1'b0, route_basic_ff[6:4]}; // see R6 see R8

    // two event routers
    logic [1:0] routed;
    logic [3:0] codes [2];
    assign codes[0] = code_one;
    assign codes[1] = code_two;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_route
            mtr_event_router u_router (
                .i_clock(i_clock),
                .i_rst_n(i_rst_n),
                .i_code(codes[g]),
                .i_events(events),
                .o_pulse(routed[g])
            );
        end
    endgenerate
    assign o_event_out_one = routed[0];
    assign o_event_out_two = routed[1];

    // sticky status, mask and interrupt
    mtr_sticky_irq u_irq (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_events(events),
        .i_stat_clr(wr_done && sel_stat),
        .i_mask_wr(wr_done && sel_mask),
        .i_wdata(i_pwdata[`MTR_NUM_EVT-1:0]),
        .o_status(irq_stat),
        .o_mask(irq_mask),
        .o_irq(o_irq)
    );

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;

    // checks
    chk_hi_latch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        lo_read |=> count_hi_ff == $past(i_count_value[15:8])) // see R1
        else $error("high byte not latched on low read");
    chk_wrap_upper: assert property (@(posedge i_clock)
        disable iff (!i_rst_n)
        w0_read |=> wrap_snap_ff[23:8] == $past(i_wrap_value[23:8])) // see R1
        else $error("wrap upper bytes not latched");
    chk_coherent_snap: assert property (@(posedge i_clock)
        disable iff (!i_rst_n)
        lo_read && latch_mode_ff |=> wrap_snap_ff == $past(i_wrap_value)
        ##1 $stable(wrap_snap_ff) || $past(lo_read || w0_read)) // see R2
        else $error("snapshot not coherent");
    chk_sync_now: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !sync_ff && run_ff != o_timer_running |=>
        o_timer_running == $past(run_ff)) // see R3
        else $error("immediate start or stop missed");
    chk_sync_wait: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        sync_ff && !slow_rise |=> $stable(o_timer_running)) // see R4
        else $error("deferred change without slow edge");
    chk_run_back: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_done && sel_ctrl |=> run_ff == $past(i_pwdata[0])) // see R5
        else $error("run bit not written");
    chk_route_none: assert property (@(posedge i_clock)
        disable iff (!i_rst_n)
        !ext_layout_ff && route_basic_ff[2:0] == `MTR_CODE_BASIC_NONE
        |=> !o_event_out_one) // see R7
        else $error("no-event code produced a pulse");
    chk_route_period: assert property (@(posedge i_clock)
        disable iff (!i_rst_n)
        code_two == 4'h0 |=> o_event_out_two == $past(events[0])) // see R6
        else $error("period event not routed");
    chk_route_long: assert property (@(posedge i_clock)
        disable iff (!i_rst_n)
        ext_layout_ff && route_ext_ff[3:0] == `MTR_CODE_LONG_ONE
        |=> o_event_out_one == $past(events[6])) // see R8 see R9
        else $error("combined match not routed");
    chk_state_bit: assert property (@(posedge i_clock)
        disable iff (!i_rst_n)
        setup_rd && sel_ctrl |=> o_prdata[2] == $past(o_timer_running)
        && o_prdata[7:4] == 4'h0) // see R10
        else $error("state bit read wrong");
    chk_period_hit: assert property (@(posedge i_clock)
        disable iff (!i_rst_n)
        running && i_count_value == 16'h0000 && count_prev_ff == 16'h0001
        |-> events[0]) // see R11
        else $error("wrap to zero gave no period event");
    chk_combined: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        events[7] |-> i_wrap_equals_two && i_count_match_two) // see R12
        else $error("combined match without both matches");
endmodule
`default_nettype wire

//--- test/mtr_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module mtr_core_model #(
    parameter int PERIOD = 600,
    parameter logic [23:0] WRAP_START = 24'h12FFFD,
    parameter int SLOW_HALF = 8
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // control from the block and the bench
    input wire logic i_running,
    input wire logic [5:0] i_fire,
    // status towards the block
    output logic o_slow_clock,
    output logic [15:0] o_count_value,
    output logic [23:0] o_wrap_value,
    output logic [5:0] o_match
);
    logic [15:0] slow_cnt;

    // counter wraps to zero instead of reaching the period
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_count_value <= 16'h0000;
            o_wrap_value <= WRAP_START;
        end else if (i_running) begin
            if (o_count_value == 16'(PERIOD - 1)) begin
                o_count_value <= 16'h0000;
                o_wrap_value <= o_wrap_value + 24'h000001;
            end else begin
                o_count_value <= o_count_value + 16'h0001;
            end
        end
    end

    // slow clock runs free, also in reset
    always @(posedge i_clock) begin
        if (slow_cnt >= 16'(SLOW_HALF - 1)) begin
            slow_cnt <= 16'h0000;
            o_slow_clock <= ~o_slow_clock;
        end else begin
            slow_cnt <= slow_cnt + 16'h0001;
        end
    end

    initial begin
        slow_cnt = 16'h0000;
        o_slow_clock = 1'b0;
    end

    // match pulses and equality levels come straight from the bench
    assign o_match = i_fire;
endmodule

`default_nettype wire

//--- test/mac_timer_control_event_routing_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mtr_consts.svh"

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
    bad_count++; $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
    end end

module mac_timer_control_event_routing_bench
    import mtr_pkg::*;
;
    logic i_clock = 0, i_rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, slow, running, ev1, ev2, irq;
    logic [15:0] cnt, sc;
    logic [23:0] wrp, sw, lw;
    logic [5:0] fire = 6'h00, match;
    logic [3:0] c1, c2, n1, n2;
    logic [7:0] np;
    int bad_count = 0, tests_run = 0, cycles = 0, k;

    always #4 i_clock = ~i_clock;

    mtr_timer_ctrl mtr_timer_ctrl_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_slow_clock(slow),
        .i_count_value(cnt), .i_wrap_value(wrp),
        .i_count_match_one(match[0]), .i_count_match_two(match[1]),
        .i_wrap_match_one(match[2]), .i_wrap_match_two(match[3]),
        .i_wrap_equals_one(match[4]), .i_wrap_equals_two(match[5]),
        .o_timer_running(running), .o_event_out_one(ev1),
        .o_event_out_two(ev2), .o_irq(irq));

    mtr_core_model mtr_core_model_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_running(running), .i_fire(fire), .o_slow_clock(slow),
        .o_count_value(cnt), .o_wrap_value(wrp), .o_match(match));

    // one apb transfer; counter snapshot taken at the setup edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge i_clock);
        sc = cnt;
        sw = wrp;
        penable <= 1'b1;
        // only the bench timeout ends a hung access
        do begin
            @(posedge i_clock);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, {24'h000000, e}, q)
    endtask

    // fire every non-period source once, count routed pulses
    task fire_all();
        @(posedge i_clock) fire <= 6'h3F;
        @(posedge i_clock) fire <= 6'h00;
        n1 = 4'h0;
        n2 = 4'h0;
        repeat (4) begin
            @(posedge i_clock);
            n1 = n1 + {3'h0, ev1};
            n2 = n2 + {3'h0, ev2};
        end
    endtask

    function automatic logic [3:0] hit(input logic [3:0] c);
        return (c inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9}) ? 4'h1 : 4'h0;
    endfunction

    task results();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd_chk("ctrl reset", `MTR_OFF_CTRL, 8'h02);
        rd_chk("irq status reset", `MTR_OFF_IRQ_STAT, 8'h00);
        apb(1'b0, 8'hFC, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, q)
        apb(1'b1, `MTR_OFF_ROUTE, 32'hFF);
        rd_chk("route basic mask", `MTR_OFF_ROUTE, 8'h77);
        // every code of both layouts on both outputs, timer stopped
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, `MTR_OFF_SEL, e ? 32'h100 : 32'h0);
            for (int c = 0; c < (e ? 16 : 8); c++) begin
                c1 = 4'(c);
                c2 = (e ? 4'hF : 4'h7) - c1;
                if (e) apb(1'b1, `MTR_OFF_ROUTE_EXT, {24'h0, c2, c1});
                else apb(1'b1, `MTR_OFF_ROUTE, {25'h0, c2[2:0], 1'b0, c1[2:0]});
                fire_all();
                `CHK("route one", hit(c1), n1)
                `CHK("route two", hit(c2), n2)
            end
        end
        rd_chk("irq status", `MTR_OFF_IRQ_STAT, 8'hF6);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, `MTR_OFF_IRQ_MASK, 32'h02);
        #1 `CHK("irq raised", 1'b1, irq)
        apb(1'b1, `MTR_OFF_IRQ_STAT, 32'h02);
        #1 `CHK("irq cleared", 1'b0, irq)
        rd_chk("irq status w1c", `MTR_OFF_IRQ_STAT, 8'hF4);
        // immediate start on the fast clock
        apb(1'b1, `MTR_OFF_SEL, 32'h0);
        apb(1'b1, `MTR_OFF_ROUTE, 32'h70);
        apb(1'b1, `MTR_OFF_CTRL, 32'h01);
        #1 `CHK("not yet running", 1'b0, running)
        @(posedge i_clock);
        #1 `CHK("running next cycle", 1'b1, running)
        np = 8'h00;
        repeat (1250) begin
            @(posedge i_clock);
            np = np + {7'h0, ev1};
        end
        `CHK("period pulses", 8'h02, np)
        // latch mode 0
        rd_chk("count low live", `MTR_OFF_CNT_LO, cnt[7:0] + 8'h02);
        `CHK("count low snap", {24'h0, sc[7:0]}, q)
        repeat (300) @(posedge i_clock);
        rd_chk("count high latch", `MTR_OFF_CNT_HI, sc[15:8]);
        apb(1'b0, `MTR_OFF_WRAP0, 32'h0);
        lw = sw;
        `CHK("wrap0 live", {24'h0, sw[7:0]}, q)
        repeat (700) @(posedge i_clock);
        rd_chk("wrap1 latch", `MTR_OFF_WRAP1, lw[15:8]);
        rd_chk("wrap2 latch", `MTR_OFF_WRAP2, lw[23:16]);
        // latch mode 1 takes one coherent snapshot
        apb(1'b1, `MTR_OFF_CTRL, 32'h09);
        apb(1'b0, `MTR_OFF_CNT_LO, 32'h0);
        lw = sw;
        `CHK("mode1 low", {24'h0, sc[7:0]}, q)
        repeat (700) @(posedge i_clock);
        rd_chk("mode1 high", `MTR_OFF_CNT_HI, sc[15:8]);
        rd_chk("mode1 wrap0", `MTR_OFF_WRAP0, lw[7:0]);
        rd_chk("mode1 wrap1", `MTR_OFF_WRAP1, lw[15:8]);
        rd_chk("mode1 wrap2", `MTR_OFF_WRAP2, lw[23:16]);
        apb(1'b1, `MTR_OFF_CTRL, 32'h00);
        @(posedge i_clock);
        #1 `CHK("stopped", 1'b0, running)
        // deferred start on the slow clock edge
        // start in the high phase so the next rise is well after readback
        while (slow !== 1'b1) @(posedge i_clock);
        apb(1'b1, `MTR_OFF_CTRL, 32'h03);
        rd_chk("run readback", `MTR_OFF_CTRL, 8'h03);
        `CHK("deferred idle", 1'b0, running)
        for (k = 0; k < 40 && running !== 1'b1; k++) begin
            @(posedge i_clock);
            #1;
        end
        `CHK("start at slow edge", 1'b1, running & slow)
        rd_chk("state running", `MTR_OFF_CTRL, 8'h07);
        results();
    end
endmodule

`default_nettype wire
